// File: rtl/ird_pkg.sv
package ird_pkg;
   // ==========================================================
   // Interrupt address decode
   // ==========================================================
   localparam int          IRD_ID_HI      = 31;
   localparam int          IRD_ID_LO      = 20;
   localparam logic [11:0] IRD_ID_VALUE   = 12'hfee;
   localparam int          IRD_HANDLE_HI  = 19;
   localparam int          IRD_HANDLE_LO  = 5;
   localparam int          IRD_FMT_BIT    = 4;
   localparam int          IRD_SHV_BIT    = 3;
   localparam int          IRD_HANDLE_MSB = 2;
   // ==========================================================
   // Data word fields
   // ==========================================================
   localparam int          IRD_RSV_HI     = 31;
   localparam int          IRD_RSV_LO     = 16;
   localparam int          IRD_SUB_HI     = 15;
   localparam int          IRD_SUB_LO     = 0;
   // ==========================================================
   // Requester identity
   // ==========================================================
   localparam int          IRD_BUS_LO     = 8;
   localparam logic [7:0]  IRD_DEVFN_ZERO = 8'h00;
   // ==========================================================
   // Output classes and source kinds
   // ==========================================================
   typedef enum logic [1:0] {
      IRD_CLS_COMPAT,
      IRD_CLS_REMAP,
      IRD_CLS_BLOCKED
   } ird_class_t;
   typedef enum logic [1:0] {
      IRD_SRC_PCIE,
      IRD_SRC_PCIX_BRIDGE,
      IRD_SRC_PCI_BRIDGE,
      IRD_SRC_PLATFORM
   } ird_src_t;
endpackage

// File: rtl/ird_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RL1] Address bits 31:20 equal FEEh means interrupt.
// [RL2] Internal unit events skip the remap path.
// [RL3] Format bit 4 clear gives compatibility format.
// [RL4] Format bit 4 set gives remappable format.
// [RL5] Handle is bit 2 over bits 19:5.
// [RL6] Full 16-bit handle space is distinguished.
// [RL7] Address bit 3 is subhandle_valid flag.
// [RL8] Address bits 1:0 are ignored.
// [RL9] Data 31:16 must be zero when valid.
// [RL10] Data 15:0 is subhandle when valid.
// [RL11] Requester id from header is requester_identity.
// [RL12] Bridge-aliased ids accepted, not isolated.
// [RL13] Conventional bridge id used as identity.
// [RL14] Controllers supply unique 16-bit identities.
// [RL15] Platform sources supply unique identities.
// [RL16] Without remapping only compatibility format.
// [RL17] Remap capability is reported to software.
// [RL18] Index is handle, plus subhandle if valid.
// [RL19] Nonzero reserved bits block remappable request if subhandle valid.
// [RL20] Results appear with one strobe next cycle.
module ird_decoder #(
   parameter bit REMAP_SUPPORTED = 1'b1
) (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic        wr_valid,
   input  wire logic [31:0] wr_addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_dword,
   input  wire logic [15:0] wr_requester_id,
   input  wire ird_pkg::ird_src_t wr_src_kind,
   input  wire logic        wr_internal,
   output logic             wr_ready,
   output logic             remap_capable,
   output logic             int_valid,
   output ird_pkg::ird_class_t int_class,
   output logic             int_format,
   output logic [15:0]      int_handle,
   output logic             int_subhandle_valid,
   output logic [15:0]      int_subhandle,
   output logic [15:0]      int_index,
   output logic [15:0]      int_requester_identity,
   output logic             int_isolated,
   output logic             int_bypass
);
   import ird_pkg::*;

   // ==========================================================
   // Field extraction
   // ==========================================================
   // Builds the 16-bit handle; bits 1:0 never take part.
   function automatic logic [15:0] ird_handle(input logic [31:0] a);
      ird_handle = {a[IRD_HANDLE_MSB], a[IRD_HANDLE_HI:IRD_HANDLE_LO]}; // RL5
   endfunction

   logic        is_interrupt;
   logic        fmt_remap;
   logic        subhandle_valid;
   logic        rsv_bad;
   logic [15:0] handle;
   logic [15:0] subhandle;
   logic [15:0] index;
   logic        take;
   ird_class_t  cls;

   // Requests are always accepted; the decoder never stalls.
   assign wr_ready      = 1'b1;
   assign remap_capable = REMAP_SUPPORTED; // RL17
   assign take          = wr_valid & clk_en;

   // Classification of the incoming write.
   assign is_interrupt = wr_dword & ~wr_internal
                       & (wr_addr[IRD_ID_HI:IRD_ID_LO] == IRD_ID_VALUE); // RL1
   assign fmt_remap = wr_addr[IRD_FMT_BIT] & REMAP_SUPPORTED; // RL4 RL16
   assign subhandle_valid       = wr_addr[IRD_SHV_BIT]; // RL7
   assign handle    = ird_handle(wr_addr); // RL6 RL8
   // Reserved data is only checked when the subhandle is in use.
   assign rsv_bad   = subhandle_valid & (wr_data[IRD_RSV_HI:IRD_RSV_LO] != 16'h0000); // RL9
   assign subhandle = subhandle_valid ? wr_data[IRD_SUB_HI:IRD_SUB_LO] : 16'h0000; // RL10
   // Index wraps at 16 bits; bounds checking happens downstream.
   assign index     = subhandle_valid ? 16'(handle + subhandle) : handle; // RL18
   // Without remap support a set format bit still decodes as compat.
   assign cls = !fmt_remap ? IRD_CLS_COMPAT // RL3
              : rsv_bad    ? IRD_CLS_BLOCKED // RL19
              :              IRD_CLS_REMAP;

   // ==========================================================
   // Output registers
   // ==========================================================
   // Internal events and non-interrupt writes produce only a bypass mark.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         int_valid  <= 1'b0;
         int_bypass <= 1'b0;
      end else if (clk_en) begin
         int_valid  <= wr_valid & is_interrupt; // RL20
         int_bypass <= wr_valid & ~is_interrupt; // RL2
      end
   end

   // Payload fields; blocked requests keep handle, subhandle, index and identity cleared.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         int_class              <= IRD_CLS_COMPAT;
         int_format             <= 1'b0;
         int_handle             <= 16'h0000;
         int_subhandle_valid    <= 1'b0;
         int_subhandle          <= 16'h0000;
         int_index              <= 16'h0000;
         int_requester_identity <= 16'h0000;
         int_isolated           <= 1'b0;
      end else if (take && is_interrupt) begin
         int_class  <= cls;
         int_format <= fmt_remap;
         int_handle <= (cls == IRD_CLS_REMAP) ? handle : 16'h0000;
         int_subhandle_valid <= (cls == IRD_CLS_REMAP) & subhandle_valid;
         int_subhandle <= (cls == IRD_CLS_REMAP) ? subhandle : 16'h0000;
         int_index  <= (cls == IRD_CLS_REMAP) ? index : 16'h0000;
         int_requester_identity <= (cls == IRD_CLS_BLOCKED) ? 16'h0000
                                 : wr_requester_id; // RL11 RL13 RL14 RL15
         // Bridge-attached sources alias, so no per-device isolation.
         int_isolated <= (wr_src_kind == IRD_SRC_PCIE)
                       | (wr_src_kind == IRD_SRC_PLATFORM); // RL12 RL13
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_take_fee;
      clk_en && wr_valid && wr_dword && !wr_internal
         && wr_addr[IRD_ID_HI:IRD_ID_LO] == IRD_ID_VALUE;
   endsequence

   AST_ID_STROBE: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee |=> int_valid) // RL1
      else $error("Interrupt write gave no valid strobe.");
   AST_NOT_FEE: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && wr_valid && wr_addr[IRD_ID_HI:IRD_ID_LO] != IRD_ID_VALUE
      |=> !int_valid) // RL1
      else $error("Non-interrupt address was decoded.");
   AST_INTERNAL: assert property (@(posedge ref_clk) disable iff (!rstn)
      clk_en && wr_valid && wr_internal |=> int_bypass && !int_valid) // RL2
      else $error("Internal event entered the remap path.");
   AST_COMPAT: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee ##0 !wr_addr[4] |=> int_class == IRD_CLS_COMPAT) // RL3
      else $error("Format clear not compatibility.");
   AST_REMAP: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee ##0 wr_addr[4] && !wr_addr[3] && REMAP_SUPPORTED
      |=> int_class == IRD_CLS_REMAP && int_format) // RL4
      else $error("Format set not remappable.");
   AST_HANDLE: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee ##0 wr_addr[4] && !wr_addr[3] && REMAP_SUPPORTED
      |=> int_handle == {$past(wr_addr[2]), $past(wr_addr[19:5])}) // RL5
      else $error("Handle assembled wrongly.");
   AST_SHV: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee ##0 wr_addr[4] && wr_addr[3]
      && wr_data[31:16] == 16'h0000 && REMAP_SUPPORTED
      |=> int_subhandle_valid
          && int_subhandle == $past(wr_data[15:0])) // RL7 RL10
      else $error("Subhandle not captured.");
   AST_RSV: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee ##0 wr_addr[4] && wr_addr[3]
      && wr_data[31:16] != 16'h0000 && REMAP_SUPPORTED
      |=> int_class == IRD_CLS_BLOCKED && int_handle == 16'h0000) // RL9 RL19
      else $error("Reserved bits not blocked.");
   AST_INDEX: assert property (@(posedge ref_clk) disable iff (!rstn)
      int_valid && int_class == IRD_CLS_REMAP
      |-> int_index == (int_subhandle_valid
          ? 16'(int_handle + int_subhandle) : int_handle)) // RL18
      else $error("Index mismatch.");
   AST_SRCID: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee ##0 !wr_addr[4]
      |=> int_requester_identity == $past(wr_requester_id)) // RL11
      else $error("Requester identity not carried.");
   AST_NO_REMAP: assert property (@(posedge ref_clk) disable iff (!rstn)
      !REMAP_SUPPORTED && int_valid |-> int_class == IRD_CLS_COMPAT) // RL16
      else $error("Remappable seen without support.");
   AST_BRIDGE: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_take_fee ##0 wr_src_kind == IRD_SRC_PCIX_BRIDGE
      |=> !int_isolated) // RL12
      else $error("Bridge request marked isolated.");

   // ==========================================================
   // Checks on bypass, freeze, index and identity
   // ==========================================================
   // An accepted interrupt write whose format bit asks for remapping.
   sequence s_take_remap;
      s_take_fee ##0 wr_addr[IRD_FMT_BIT] && REMAP_SUPPORTED;
   endsequence

   // A remappable write whose subhandle is in use and clean.
   sequence s_take_shv_clean;
      s_take_remap ##0 wr_addr[IRD_SHV_BIT]
         && wr_data[IRD_RSV_HI:IRD_RSV_LO] == 16'h0000;
   endsequence

   // A remappable write whose reserved data bits are dirty.
   sequence s_take_dirty;
      s_take_remap ##0 wr_addr[IRD_SHV_BIT]
         && wr_data[IRD_RSV_HI:IRD_RSV_LO] != 16'h0000;
   endsequence

   // Partial writes are never interrupts, whatever their address.
   AST_NON_DWORD: assert property (@(posedge ref_clk) disable iff (!rstn) // RL1
      clk_en && wr_valid && !wr_dword |=> int_bypass && !int_valid)
      else $error("Partial write entered the remap path.");

   // With the enable high, no offer means no strobe of either kind on the next cycle.
   AST_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn) // RL20
      clk_en && !wr_valid |=> !int_valid && !int_bypass)
      else $error("Strobe without an offered write.");

   // A write is either an interrupt or a bypass, never both.
   AST_EXCLUSIVE: assert property (@(posedge ref_clk) disable iff (!rstn) // RL2
      !(int_valid && int_bypass))
      else $error("Valid and bypass raised together.");

   // A low enable freezes strobes and payload alike.
   AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!rstn) // RL20
      !clk_en |=> $stable(int_valid) && $stable(int_bypass)
          && $stable(int_handle) && $stable(int_index))
      else $error("State moved while the enable was low.");

   // Payload holds between interrupts so consumers may sample late.
   AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn) // RL20
      !wr_valid |=> $stable(int_class)
          && $stable(int_requester_identity))
      else $error("Payload changed without a write.");

   // Without a subhandle the index is the handle itself.
   AST_IDX_NO_SHV: assert property (@(posedge ref_clk) disable iff (!rstn) // RL18
      s_take_remap ##0 !wr_addr[IRD_SHV_BIT]
      |=> int_index == int_handle && !int_subhandle_valid
          && int_subhandle == 16'h0000)
      else $error("Index differs from handle without subhandle.");

   // With a subhandle the index is the wrapped sum of both fields.
   AST_IDX_SHV: assert property (@(posedge ref_clk) disable iff (!rstn) // RL18
      s_take_shv_clean
      |=> int_index == 16'({$past(wr_addr[2]), $past(wr_addr[19:5])}
          + $past(wr_data[15:0])))
      else $error("Index is not handle plus subhandle.");

   // Reserved data is don't-care while the subhandle is unused.
   AST_RSV_IGNORED: assert property (@(posedge ref_clk) disable iff (!rstn) // RL9
      s_take_remap ##0 !wr_addr[IRD_SHV_BIT]
         && wr_data[IRD_RSV_HI:IRD_RSV_LO] != 16'h0000
      |=> int_class == IRD_CLS_REMAP)
      else $error("Unused reserved bits blocked a request.");

   // Blocked requests leak no identity, index or subhandle.
   AST_BLOCK_ID: assert property (@(posedge ref_clk) disable iff (!rstn) // RL19
      s_take_dirty
      |=> int_requester_identity == 16'h0000 && int_index == 16'h0000
          && int_subhandle == 16'h0000 && !int_subhandle_valid)
      else $error("Blocked request carried fields.");

   // A clean remappable request carries the header requester id.
   AST_REMAP_ID: assert property (@(posedge ref_clk) disable iff (!rstn) // RL11
      s_take_remap ##0 !wr_addr[IRD_SHV_BIT]
      |=> int_requester_identity == $past(wr_requester_id))
      else $error("Remappable request lost its identity.");

   // Direct endpoints are the only bus sources that isolate.
   AST_ISO_PCIE: assert property (@(posedge ref_clk) disable iff (!rstn) // RL11
      s_take_fee ##0 wr_src_kind == IRD_SRC_PCIE |=> int_isolated)
      else $error("Endpoint request not isolated.");

   // A conventional bridge hides the devices behind it.
   AST_ISO_PCI_BR: assert property (@(posedge ref_clk) disable iff (!rstn) // RL13
      s_take_fee ##0 wr_src_kind == IRD_SRC_PCI_BRIDGE |=> !int_isolated)
      else $error("Conventional bridge request isolated.");

   // Platform sources own unique ids, so they isolate too.
   AST_ISO_PLAT: assert property (@(posedge ref_clk) disable iff (!rstn) // RL15
      s_take_fee ##0 wr_src_kind == IRD_SRC_PLATFORM |=> int_isolated)
      else $error("Platform request not isolated.");

   // The format flag agrees with the class on every strobe.
   AST_FMT_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
      int_valid |-> int_format == (int_class != IRD_CLS_COMPAT))
      else $error("Format flag disagrees with class.");

   // Compatibility requests pass no remap fields downstream.
   AST_COMPAT_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
      s_take_fee ##0 !fmt_remap
      |=> int_handle == 16'h0000 && int_index == 16'h0000)
      else $error("Compatibility request carried remap fields.");
endmodule
`default_nettype wire

// File: bench/ird_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Upstream write source
// ==========================================================
module ird_src_model (
   input  wire logic             ref_clk,
   output logic                  wr_valid,
   output logic [31:0]           wr_addr,
   output logic [31:0]           wr_data,
   output logic                  wr_dword,
   output logic [15:0]           wr_requester_id,
   output ird_pkg::ird_src_t     wr_src_kind,
   output logic                  wr_internal
);
   import ird_pkg::*;
   // Lines start quiet; a released bus shows inverted address and data, restored by a second release.
   initial begin
      wr_valid = 1'b0;
      wr_addr = 32'h0;
      wr_data = 32'h0;
      wr_dword = 1'b0;
      wr_requester_id = 16'h0;
      wr_src_kind = IRD_SRC_PCIE;
      wr_internal = 1'b0;
   end
   // One write held over one rising edge, returning just after it.
   task automatic send(input logic [31:0] a, d, input logic [15:0] id,
                       input ird_src_t k, input logic in, dw);
      wr_valid = 1'b1;
      wr_addr = a;
      wr_data = d;
      wr_requester_id = id;
      wr_src_kind = k;
      wr_internal = in;
      wr_dword = dw;
      @(posedge ref_clk);
      #1;
   endtask
   // Release, so a decoder that reuses old fields sees garbage.
   task automatic idle();
      wr_valid = 1'b0;
      wr_addr = ~wr_addr;
      wr_data = ~wr_data;
      @(posedge ref_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// File: bench/tb_interrupt_request_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Decoder bench
// ==========================================================
module tb_interrupt_request_decoder;
   import ird_pkg::*;
   typedef struct {
      logic [31:0] a, d;
      logic [15:0] id;
      ird_src_t k;
      logic in, dw, byp;
      ird_class_t c;
      logic [15:0] h, s, x;
   } ird_row_t;
   logic ref_clk, rstn, clk_en, wr_valid, wr_dword, wr_internal, wr_ready;
   logic [31:0] wr_addr, wr_data;
   logic [15:0] wr_requester_id, int_handle, int_subhandle, int_index;
   logic [15:0] int_requester_identity;
   ird_src_t wr_src_kind;
   ird_class_t int_class;
   logic remap_capable, int_valid, int_format, int_subhandle_valid;
   logic int_isolated, int_bypass, nr_cap, nr_format;
   ird_class_t nr_class;
   int err_count, comparisons, cyc;
   ird_row_t rows [8];
   ird_decoder uut (.ref_clk, .rstn, .clk_en, .wr_valid, .wr_addr, .wr_data,
      .wr_dword, .wr_requester_id, .wr_src_kind, .wr_internal, .wr_ready,
      .remap_capable, .int_valid, .int_class, .int_format, .int_handle,
      .int_subhandle_valid, .int_subhandle, .int_index,
      .int_requester_identity, .int_isolated, .int_bypass);
   ird_decoder #(.REMAP_SUPPORTED(1'b0)) uut_compat (.ref_clk, .rstn, .clk_en,
      .wr_valid, .wr_addr, .wr_data, .wr_dword, .wr_requester_id, .wr_src_kind,
      .wr_internal, .wr_ready(), .remap_capable(nr_cap), .int_valid(),
      .int_class(nr_class), .int_format(nr_format), .int_handle(),
      .int_subhandle_valid(), .int_subhandle(), .int_index(),
      .int_requester_identity(), .int_isolated(), .int_bypass());
   ird_src_model src (.ref_clk, .wr_valid, .wr_addr, .wr_data, .wr_dword,
      .wr_requester_id, .wr_src_kind, .wr_internal);
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic put(input int i);
      src.send(rows[i].a, rows[i].d, rows[i].id, rows[i].k, rows[i].in,
               rows[i].dw);
   endtask
   // Clock; the run is a few dozen cycles, so 500 marks a hang.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 500) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      rows = '{
       '{32'hfee0_0018, 32'h5, 16'h0100, IRD_SRC_PCIE, 1'b0, 1'b1, 1'b0,
         IRD_CLS_REMAP, 16'h0, 16'h5, 16'h5},
       '{32'hfeef_fff7, 32'hffff_1234, 16'h0208, IRD_SRC_PCIX_BRIDGE, 1'b0,
         1'b1, 1'b0, IRD_CLS_REMAP, 16'hffff, 16'h0, 16'hffff},
       '{32'hfee0_003c, 32'h0000_ffff, 16'h0310, IRD_SRC_PCI_BRIDGE, 1'b0,
         1'b1, 1'b0, IRD_CLS_REMAP, 16'h8001, 16'hffff, 16'h8000},
       '{32'hfee0_0018, 32'h0001_0000, 16'h0f0f, IRD_SRC_PLATFORM, 1'b0,
         1'b1, 1'b0, IRD_CLS_BLOCKED, 16'h0, 16'h0, 16'h0},
       '{32'hfee0_0000, 32'h1234, 16'h00f8, IRD_SRC_PCIE, 1'b0, 1'b1, 1'b0,
         IRD_CLS_COMPAT, 16'h0, 16'h0, 16'h0},
       '{32'hfed0_0018, 32'h5, 16'h1, IRD_SRC_PCIE, 1'b0, 1'b1, 1'b1,
         IRD_CLS_COMPAT, 16'h0, 16'h0, 16'h0},
       '{32'hfee0_0018, 32'h5, 16'h1, IRD_SRC_PCIE, 1'b1, 1'b1, 1'b1,
         IRD_CLS_COMPAT, 16'h0, 16'h0, 16'h0},
       '{32'hfee0_0018, 32'h5, 16'h1, IRD_SRC_PCIE, 1'b0, 1'b0, 1'b1,
         IRD_CLS_COMPAT, 16'h0, 16'h0, 16'h0}};
      rstn = 1'b0;
      clk_en = 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(int_valid, 1'b0);
      chk(remap_capable, 1'b1);
      chk(nr_cap, 1'b0);
      chk(wr_ready, 1'b1);
      #1 rstn = 1'b1;
      // Table rows, each followed by an idle cycle.
      for (int i = 0; i < 8; i++) begin
         put(i);
         chk(int_valid, !rows[i].byp);
         chk(int_bypass, rows[i].byp);
         if (!rows[i].byp) begin
            chk(int_class, rows[i].c);
            chk(int_handle, rows[i].h);
            chk(int_subhandle, rows[i].s);
            chk(int_index, rows[i].x);
            chk(int_requester_identity, rows[i].c == IRD_CLS_BLOCKED ?
                16'h0 : rows[i].id);
            chk(int_isolated, rows[i].k == IRD_SRC_PCIE ||
                rows[i].k == IRD_SRC_PLATFORM);
            chk(nr_class, IRD_CLS_COMPAT);
            chk(nr_format, 1'b0);
         end
         if (rows[i].c == IRD_CLS_REMAP) begin
            chk(int_format, 1'b1);
            chk(int_subhandle_valid, rows[i].a[3]);
         end
         src.idle();
      end
      // Back to back, then a frozen pulse must stand while clk_en is low.
      put(0);
      chk(int_index, 16'h5);
      put(2);
      chk(int_valid, 1'b1);
      chk(int_index, 16'h8000);
      clk_en = 1'b0;
      src.idle();
      chk(int_valid, 1'b1);
      clk_en = 1'b1;
      src.idle();
      chk(int_valid, 1'b0);
      chk(int_handle, 16'h8001);
      // Mid-run reset clears held payload at once.
      rstn = 1'b0;
      #1;
      chk(int_handle, 16'h0);
      src.idle();
      rstn = 1'b1;
      put(0);
      chk(int_valid, 1'b1);
      chk(int_index, 16'h5);
      print_verdict();
   end
endmodule
`default_nettype wire
